// >>> cwrw_defines.svh
`ifndef CWRW_DEFINES_SVH
`define CWRW_DEFINES_SVH
// ---------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------
`define CWRW_OFS_CTRL 8'h00
`define CWRW_OFS_STAT 8'h04
`define CWRW_OFS_MASK 8'h08
`define CWRW_OFS_COUNT 8'h0c
// ---------------------------------------------------------------------
// Control field positions
// ---------------------------------------------------------------------
`define CWRW_BIT_IRQ_EN 0
`define CWRW_BIT_RST_EN 1
`define CWRW_BIT_CHG_EN 2
`define CWRW_POS_PERIOD 4
`define CWRW_BIT_UNLOCK 8
`define CWRW_BIT_RESTART 9
// ---------------------------------------------------------------------
// Status field positions
// ---------------------------------------------------------------------
`define CWRW_BIT_ST_TIMEOUT 0
`define CWRW_BIT_ST_WDRF 1
// ---------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------
`define CWRW_RST_PERIOD 4'h0
`define CWRW_CHG_WINDOW 3'h4
`define CWRW_OSC_HZ 128000
`define CWRW_CLK_HZ 40000000
`define CWRW_OSC_DIV ((`CWRW_CLK_HZ + `CWRW_OSC_HZ - 1) / `CWRW_OSC_HZ)
`define CWRW_CNT_W 20
`endif

// >>> cwrw_pkg.sv
package cwrw_pkg;
  typedef struct packed {
    logic irq_en;
    logic rst_en;
    logic [3:0] period;
  } cwrw_cfg_t;
  typedef enum logic [1:0] {CWRW_RUN, CWRW_WARNED, CWRW_FIRE} cwrw_state_t;
endpackage

// >>> cwrw_osc_tick.sv
`timescale 1ns/100ps
`include "cwrw_defines.svh"
// Divides clk_sys to the 128 kHz watchdog oscillator tick
module cwrw_osc_tick (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  localparam int unsigned DIV = `CWRW_OSC_DIV;
  logic [8:0] div_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      div_reg <= 9'h000;
      tick <= 1'b0;
    end else if (div_reg == 9'(DIV - 1)) begin
      div_reg <= 9'h000;
      tick <= 1'b1;
    end else begin
      div_reg <= div_reg + 9'h001;
      tick <= 1'b0;
    end
  end
endmodule // cwrw_osc_tick

// >>> cwrw_counter.sv
`timescale 1ns/100ps
`include "cwrw_defines.svh"
// Watchdog count with period limit; one-cycle timeout pulse
module cwrw_counter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  input wire logic [3:0] period,
  output logic [`CWRW_CNT_W-1:0] count,
  output logic timeout
);
  function automatic logic [`CWRW_CNT_W-1:0] limit_of(
    input logic [3:0] p);
    logic [`CWRW_CNT_W-1:0] one;
    one = {{(`CWRW_CNT_W-1){1'b0}}, 1'b1};
    limit_of = (p > 4'd9) ? (one << 11) : (one << (p + 4'd2));
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n || clear) begin
      count <= '0;
      timeout <= 1'b0;
    end else if (tick && count == limit_of(period) - 1'b1) begin
      count <= '0;
      timeout <= 1'b1;
    end else begin
      count <= count + {{(`CWRW_CNT_W-1){1'b0}}, tick};
      timeout <= 1'b0;
    end
  end
endmodule // cwrw_counter

// >>> cwrw_top.sv
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "cwrw_defines.svh"
module cwrw_top #(
  parameter bit FREE_PERIOD = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic always_on_fuse,
  input wire logic watchdog_restart_instruction,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic wake,
  output logic sys_reset_req
);
  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  cwrw_pkg::cwrw_cfg_t cfg_reg;
  cwrw_pkg::cwrw_state_t state_reg;
  logic [2:0] chg_reg;
  logic [1:0] stat_reg;
  logic [1:0] mask_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic wr_do;
  logic running;
  logic tick;
  logic timeout;
  logic [`CWRW_CNT_W-1:0] count;
  logic rst_eff;
  logic fire_reg;

  // System reset from the watchdog itself leaves config intact
  assign rst_eff = rst_n;
  assign running = cfg_reg.irq_en | cfg_reg.rst_en | always_on_fuse;
  assign wr_do = aw_have_reg & w_have_reg & ~s_axi_bvalid;

  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = (a == `CWRW_OFS_CTRL);
  endfunction

  // -------------------------------------------------------------------
  // Tick and count
  // -------------------------------------------------------------------
  cwrw_osc_tick u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(running),
    .tick(tick)
  );

  cwrw_counter u_cnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(~running | watchdog_restart_instruction | fire_reg),
    .tick(tick),
    .period(cfg_reg.period),
    .count(count),
    .timeout(timeout)
  );

  // -------------------------------------------------------------------
  // AXI4-Lite write channel
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_eff) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg[7:4] == 4'h0) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Change-enable window
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_eff) begin
      chg_reg <= 3'h0;
    end else if (wr_do && is_ctrl(awaddr_reg) && wstrb_reg[0] &&
                 wdata_reg[`CWRW_BIT_CHG_EN]) begin
      chg_reg <= `CWRW_CHG_WINDOW;
    end else if (chg_reg != 3'h0) begin
      chg_reg <= chg_reg - 3'h1;
    end
  end

  // -------------------------------------------------------------------
  // Configuration and mode sequencing
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!por_n) begin
      cfg_reg <= '{irq_en: 1'b0, rst_en: 1'b0, period: `CWRW_RST_PERIOD};
    end else begin
      if (wr_do && is_ctrl(awaddr_reg) && wstrb_reg[0]) begin
        cfg_reg.irq_en <= wdata_reg[`CWRW_BIT_IRQ_EN];
        if (wdata_reg[`CWRW_BIT_RST_EN]) begin
          cfg_reg.rst_en <= 1'b1;
        end else if (chg_reg != 3'h0) begin
          cfg_reg.rst_en <= 1'b0;
        end
        if (chg_reg != 3'h0 || (FREE_PERIOD && !always_on_fuse)) begin
          cfg_reg.period <= wdata_reg[`CWRW_POS_PERIOD +: 4];
        end
      end
      if (always_on_fuse) begin
        cfg_reg.rst_en <= 1'b1;
        cfg_reg.irq_en <= 1'b0;
      end
      if (timeout && cfg_reg.irq_en && cfg_reg.rst_en) begin
        cfg_reg.irq_en <= 1'b0;
      end
    end
  end

  // Reset request is a one-cycle pulse, one cycle after fire_reg; only por_n resets it
  always_ff @(posedge clk_sys) begin
    if (!por_n) begin
      fire_reg <= 1'b0;
      sys_reset_req <= 1'b0;
      wake <= 1'b0;
      state_reg <= cwrw_pkg::CWRW_RUN;
    end else begin
      fire_reg <= timeout & (cfg_reg.rst_en | always_on_fuse) &
                  ~cfg_reg.irq_en;
      sys_reset_req <= fire_reg;
      wake <= timeout & cfg_reg.irq_en;
      unique case (state_reg)
        cwrw_pkg::CWRW_RUN:
          if (timeout && cfg_reg.irq_en) state_reg <= cwrw_pkg::CWRW_WARNED;
          else if (fire_reg) state_reg <= cwrw_pkg::CWRW_FIRE;
        cwrw_pkg::CWRW_WARNED:
          if (fire_reg) state_reg <= cwrw_pkg::CWRW_FIRE;
          else if (watchdog_restart_instruction)
            state_reg <= cwrw_pkg::CWRW_RUN;
        cwrw_pkg::CWRW_FIRE:
          state_reg <= cwrw_pkg::CWRW_RUN;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Status, mask, interrupt
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!por_n) begin
      stat_reg <= 2'h0;
      mask_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (wr_do && awaddr_reg == `CWRW_OFS_STAT && wstrb_reg[0])
        stat_reg <= stat_reg & ~wdata_reg[1:0];
      if (wr_do && awaddr_reg == `CWRW_OFS_MASK && wstrb_reg[0])
        mask_reg <= wdata_reg[1:0];
      if (timeout && cfg_reg.irq_en)
        stat_reg[`CWRW_BIT_ST_TIMEOUT] <= 1'b1;
      if (fire_reg)
        stat_reg[`CWRW_BIT_ST_WDRF] <= 1'b1;
      irq <= |(stat_reg & mask_reg);
    end
  end

  // -------------------------------------------------------------------
  // AXI4-Lite read channel
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_eff) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          `CWRW_OFS_CTRL: s_axi_rdata <= {24'h000000, cfg_reg.period,
                                           1'b0, chg_reg != 3'h0,
                                           cfg_reg.rst_en, cfg_reg.irq_en};
          `CWRW_OFS_STAT: s_axi_rdata <= {30'h0, stat_reg};
          `CWRW_OFS_MASK: s_axi_rdata <= {30'h0, mask_reg};
          `CWRW_OFS_COUNT: s_axi_rdata <= {12'h000, count};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  first_warn_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    timeout && cfg_reg.irq_en && cfg_reg.rst_en |=> !cfg_reg.irq_en)
    else $error("interrupt mode not cleared on first timeout");
  restart_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    watchdog_restart_instruction |=> count == '0)
    else $error("restart did not clear count");
  fire_flag_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    fire_reg |=> stat_reg[1] && sys_reset_req)
    else $error("reset flag missing after watchdog reset");
  fire_state_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    state_reg == cwrw_pkg::CWRW_FIRE |-> sys_reset_req)
    else $error("reset request missing in fire state");
  fuse_hold_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    always_on_fuse |=> cfg_reg.rst_en)
    else $error("fuse did not hold reset mode");
  timed_off_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    chg_reg == 3'h0 && cfg_reg.rst_en |=> cfg_reg.rst_en)
    else $error("reset mode cleared without change-enable");
  period_lock_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    chg_reg == 3'h0 && !FREE_PERIOD |=> $stable(cfg_reg.period))
    else $error("period changed without change-enable");
  rst_set_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    wr_do && is_ctrl(awaddr_reg) && wstrb_reg[0] &&
    wdata_reg[`CWRW_BIT_RST_EN] |=> cfg_reg.rst_en)
    else $error("reset mode not set by plain write");
  wake_out_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    timeout && cfg_reg.irq_en |=> wake)
    else $error("no wake pulse after timeout");
  int_only_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    !cfg_reg.rst_en && !always_on_fuse |=> !fire_reg)
    else $error("reset issued in interrupt-only mode");
  flag_set_a: assert property (
    @(posedge clk_sys) disable iff (!por_n)
    timeout && cfg_reg.irq_en |=> stat_reg[`CWRW_BIT_ST_TIMEOUT])
    else $error("timeout flag not set");
  window_end_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    chg_reg == 3'h1 && !wr_do |=> chg_reg == 3'h0)
    else $error("change window did not expire");
  chg_open_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wr_do && is_ctrl(awaddr_reg) && wstrb_reg[0] &&
    wdata_reg[`CWRW_BIT_CHG_EN] |=> chg_reg == `CWRW_CHG_WINDOW)
    else $error("change window not opened");
  idle_clear_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !running |=> count == '0)
    else $error("count not cleared while disabled");
endmodule // cwrw_top

// >>> cwrw_core_model.sv
`timescale 1ns/100ps
`include "cwrw_defines.svh"
// ---------------------------------------------------------------------
// Core model: bus master, restarts, sleep entry
// ---------------------------------------------------------------------
module cwrw_core_model (
  input wire logic clk_sys,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic restart
);
  logic wake_marker;
  logic [1:0] bresp_seen;
  initial begin
    bresp_seen = 2'h0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    restart = 1'b0;
    wake_marker = 1'b0;
  end
  // Called just after a rising edge; returns at the bvalid edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bresp_seen = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask
  task automatic kick();
    restart <= 1'b1;
    @(posedge clk_sys);
    restart <= 1'b0;
  endtask
  // Change-enable then guarded write, nothing in between
  task automatic timed_wr(input logic [31:0] v);
    wr(`CWRW_OFS_CTRL, v | 32'h4);
    wr(`CWRW_OFS_CTRL, v);
  endtask
  // Marker and interrupt mode set before each sleep, outside any handler
  task automatic sleep_arm(input logic [31:0] v);
    wake_marker = 1'b1;
    wr(`CWRW_OFS_CTRL, v);
  endtask
endmodule // cwrw_core_model

// >>> cwrw_tb.sv
`timescale 1ns/100ps
`include "cwrw_defines.svh"
module cwrw_tb;
  logic clk_sys = 1'b0;
  logic por_n = 1'b0;
  logic boot_n = 1'b0;
  logic always_on_fuse = 1'b0;
  logic [2:0] hold = 3'h0;
  int n_rst = 0;
  logic rst_n, watchdog_restart_instruction, irq, wake, sys_reset_req;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_rresp, s_axi_bresp, r;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  assign rst_n = boot_n & (hold == 3'h0);
  always #12.5 clk_sys = ~clk_sys;
  cwrw_top dut_u (.clk_sys, .rst_n, .por_n, .always_on_fuse,
    .watchdog_restart_instruction, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .wake,
    .sys_reset_req);
  cwrw_core_model core_u (.clk_sys, .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wvalid(s_axi_wvalid), .wready(s_axi_wready),
    .bvalid(s_axi_bvalid), .bresp(s_axi_bresp), .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready),
    .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid),
    .restart(watchdog_restart_instruction));
  // System reset controller and run limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (sys_reset_req === 1'b1) begin
      hold <= 3'h3;
      n_rst <= n_rst + 1;
    end else if (hold != 3'h0)
      hold <= hold - 3'h1;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic chk(input string s, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic rdc(input string s, input logic [7:0] a,
                     input logic [31:0] exp);
    core_u.rd(a, d, r);
    chk(s, d, exp);
  endtask
  task automatic wait_evt(input bit want_rst, output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while ((want_rst ? sys_reset_req : wake) !== 1'b1 && k < 4000);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    por_n <= 1'b1;
    boot_n <= 1'b1;
    @(posedge clk_sys);
    // -----------------------------------------------------------------
    // Reset values, refused offset, untimed and timed changes
    // -----------------------------------------------------------------
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h0);
    rdc("unmapped", 8'h10, 32'h0);
    chk("resp", r, 2'h2);
    core_u.wr(8'h10, 32'h0);
    chk("bresp", core_u.bresp_seen, 2'h2);
    core_u.wr(`CWRW_OFS_CTRL, 32'h31);
    chk("bresp", core_u.bresp_seen, 2'h0);
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h01);
    core_u.timed_wr(32'h11);
    repeat (6) @(posedge clk_sys);
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h11);
    // -----------------------------------------------------------------
    // Interrupt-only timeouts, period limit, irq mask and clear
    // -----------------------------------------------------------------
    core_u.wr(`CWRW_OFS_MASK, 32'h1);
    core_u.sleep_arm(32'h11);
    core_u.kick();
    wait_evt(1'b0, n);
    chk("limit", (n > 2191 && n < 2510), 1'b1);
    rdc("stat", `CWRW_OFS_STAT, 32'h1);
    chk("irq", irq, 1'b1);
    wait_evt(1'b0, n);
    chk("wake", n < 4000, 1'b1);
    chk("rst", n_rst, 0);
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h11);
    core_u.wr(`CWRW_OFS_MASK, 32'h0);
    settle();
    chk("irq", irq, 1'b0);
    core_u.wr(`CWRW_OFS_MASK, 32'h1);
    settle();
    chk("irq", irq, 1'b1);
    core_u.wr(`CWRW_OFS_STAT, 32'h1);
    settle();
    chk("irq", irq, 1'b0);
    rdc("stat", `CWRW_OFS_STAT, 32'h0);
    // -----------------------------------------------------------------
    // Combined mode: warning, then system reset
    // -----------------------------------------------------------------
    core_u.sleep_arm(32'h13);
    core_u.kick();
    wait_evt(1'b0, n);
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h12);
    wait_evt(1'b1, n);
    @(posedge clk_sys);
    chk("rst", n_rst, 1);
    repeat (6) @(posedge clk_sys);
    core_u.rd(`CWRW_OFS_STAT, d, r);
    chk("wdrf", d[1], 1'b1);
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h12);
    core_u.rd(`CWRW_OFS_COUNT, d, r);
    chk("count", (d < 32'h2), 1'b1);
    // -----------------------------------------------------------------
    // Disable sequence: untimed, late and timed
    // -----------------------------------------------------------------
    core_u.wr(`CWRW_OFS_CTRL, 32'h10);
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h12);
    core_u.wr(`CWRW_OFS_CTRL, 32'h16);
    repeat (6) @(posedge clk_sys);
    core_u.wr(`CWRW_OFS_CTRL, 32'h10);
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h12);
    core_u.timed_wr(32'h10);
    repeat (6) @(posedge clk_sys);
    rdc("ctrl", `CWRW_OFS_CTRL, 32'h10);
    rdc("count", `CWRW_OFS_COUNT, 32'h0);
    // -----------------------------------------------------------------
    // Restarts keep reset mode from firing
    // -----------------------------------------------------------------
    core_u.wr(`CWRW_OFS_STAT, 32'h3);
    core_u.wr(`CWRW_OFS_CTRL, 32'h12);
    repeat (6) begin
      core_u.kick();
      repeat (1500) @(posedge clk_sys);
    end
    chk("rst", n_rst, 1);
    wait_evt(1'b1, n);
    @(posedge clk_sys);
    chk("rst", n_rst, 2);
    repeat (6) @(posedge clk_sys);
    // -----------------------------------------------------------------
    // Fuse programmed: reset mode held, interrupt mode forced off
    // -----------------------------------------------------------------
    always_on_fuse <= 1'b1;
    core_u.timed_wr(32'h10);
    repeat (6) @(posedge clk_sys);
    core_u.rd(`CWRW_OFS_CTRL, d, r);
    chk("rst_en", d[1], 1'b1);
    core_u.wr(`CWRW_OFS_CTRL, 32'h13);
    core_u.rd(`CWRW_OFS_CTRL, d, r);
    chk("irq_en", d[0], 1'b0);
    give_verdict();
  end
endmodule // cwrw_tb
